// ### include/pci_side_defs.svh
// Constants for the PCI-side control and CPU signal block
`ifndef PCI_SIDE_DEFS_SVH
`define PCI_SIDE_DEFS_SVH

// Register byte offsets
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_EVENT 12'h008
`define REG_IRQMAP 12'h00c

// Control register fields
`define CTRL_POLL_MODE 0
`define CTRL_INIT_LOW 1
`define CTRL_COPROC_OFF 6
`define CTRL_RESET_VAL 32'h0000_0000

// Event register bits, written as one-cycle commands
`define EV_KBC_RESET 0
`define EV_PORT92_RESET 1
`define EV_SHUTDOWN 2
`define EV_INT_ERROR 3
`define EV_SYS_RESET 4
`define EV_NMI_CLEAR 5

// Timing
`define CLK_MHZ 250
`define COLD_RESET_MS 4
`define COLD_RESET_CYC (`COLD_RESET_MS * 1000 * `CLK_MHZ)
`define INIT_PULSE_NS 64
`define INIT_PULSE_CYC ((`INIT_PULSE_NS * `CLK_MHZ) / 1000)
`define SYS_RESET_CYC 16

`endif

// ### include/pci_side_pkg.sv
// Types for the PCI-side control and CPU signal block
package pci_side_pkg;
	typedef enum logic [2:0] {
		BUS_IDLE = 3'b000,
		BUS_REQ = 3'b001,
		BUS_ADDR = 3'b011,
		BUS_DATA = 3'b010,
		BUS_PAR = 3'b110
	} bus_state_t;
endpackage

// ### src/pci_side_control.sv
// PCI-side control logic, bus ownership, parity and CPU-facing signals
//
// How it works
// - AD carries address on first clock, data on later clocks.
// - Command/byte-enable lines give command in address phase, byte enables later.
// - Parity is even across all 32 AD bits and four command bits.
// - As master, parity follows address phase and each write data phase.
// - As read target, parity follows each data phase supplied.
// - Target claim driven on positive or subtractive decode.
// - System error input sampled low asserts the non-maskable interrupt.
// - Ownership request raised for ISA, DMA, IDE and USB masters.
// - Grant from arbiter must be seen before any cycle starts.
// - Direct mode: four interrupt pins are level inputs A to D.
// - Poll mode: B, C, D drive 3-bit select; A reads encoder.
// - Maskable interrupt to CPU comes from internal controller.
// - Channel check and internal errors also assert non-maskable interrupt.
// - Cold reset held until 4 ms after power good rises.
// - Initialize output polarity chosen by configuration.
// - Initialize pulses on power-on, keyboard reset, port reset, shutdown.
// - PCI reset output is always inverse of ISA reset drive.
// - FPU error becomes IRQ13; plain IRQ13 when coprocessor disabled.
// - Shared ISA interrupt pins driven when source is not ISA.
// - DMA acknowledge only after bus granted.
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pci_side_defs.svh"

module pci_side_control
	import pci_side_pkg::*;
#(
	parameter int unsigned COLD_RESET_CYCLES = `COLD_RESET_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	// APB register port
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Internal master requests
	input wire logic [6:0] dmaRequest,
	input wire logic isaMasterReq,
	input wire logic ideMasterReq,
	input wire logic usbMasterReq,
	// Internal master cycle request
	input wire logic mstStart,
	input wire logic mstWrite,
	input wire logic [31:0] mstAddr,
	input wire logic [3:0] mstCmd,
	input wire logic [31:0] mstData,
	input wire logic [3:0] mstByteEn,
	output logic mstDone,
	// Target side decode
	input wire logic tgtPositiveHit,
	input wire logic tgtSubtractiveHit,
	input wire logic tgtReadData,
	input wire logic [31:0] tgtData,
	input wire logic [3:0] tgtByteEn,
	// PCI pins
	input wire logic [31:0] adIn,
	output logic [31:0] adOut,
	output logic adOe_n,
	output logic [3:0] cmd_byte_enable_n,
	output logic cbeOe_n,
	output logic parOut,
	output logic parOe_n,
	output logic target_claim_n,
	output logic claimOe_n,
	input wire logic system_error_in_n,
	output logic bus_own_request_n,
	input wire logic bus_own_grant_n,
	input wire logic pci_irq_a_or_poll_in,
	input wire logic pci_irq_b_or_sel0,
	output logic pci_irq_b_or_sel0Out,
	output logic pci_irq_b_or_sel0Oe_n,
	input wire logic pci_irq_c_or_sel1,
	output logic pci_irq_c_or_sel1Out,
	output logic pci_irq_c_or_sel1Oe_n,
	input wire logic pci_irq_d_or_sel2,
	output logic pci_irq_d_or_sel2Out,
	output logic pci_irq_d_or_sel2Oe_n,
	output logic [7:0] pciIrqLevel,
	output logic [6:0] dma_acknowledge_n,
	// CPU interface
	input wire logic picIntr,
	output logic cpuIntr,
	output logic cpuNmi,
	output logic cpuInit,
	output logic cpu_cold_reset_out,
	input wire logic power_good_in,
	input wire logic isa_channel_check_n,
	input wire logic fpu_error_in_n,
	output logic irq13,
	output logic isa_reset_drive,
	output logic pci_reset_out_n,
	// Shared ISA interrupts for external APIC
	input wire logic [15:0] routedIrq,
	input wire logic [15:0] irqFromIsa,
	output logic [15:0] isaIrqOut,
	output logic [15:0] isaIrqOe_n
);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [9:0] syncA_reg;
	logic [9:0] syncB_reg;
	wire logic [9:0] rawPins = {power_good_in, isa_channel_check_n, fpu_error_in_n, system_error_in_n,
		bus_own_grant_n, 1'b0, pci_irq_d_or_sel2, pci_irq_c_or_sel1, pci_irq_b_or_sel0,
		pci_irq_a_or_poll_in};

	// Two flops on each pin input
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			syncA_reg <= 10'h1ef; // Idle levels: power good low, active-low pins high
			syncB_reg <= 10'h1ef;
		end else begin
			syncA_reg <= rawPins;
			syncB_reg <= syncA_reg;
		end
	end

	wire logic pwrGood = syncB_reg[9];
	wire logic chanChkLow = ~syncB_reg[8];
	wire logic fpuErrLow = ~syncB_reg[7];
	wire logic sysErrLow = ~syncB_reg[6];
	wire logic granted = ~syncB_reg[5];
	wire logic [3:0] irqPins = syncB_reg[3:0];

	////////////////////////////////////////////////////////////////////////////////
	// APB registers
	logic [31:0] ctrl_reg;
	logic [31:0] irqMap_reg;
	wire logic wrEn = psel & penable & pwrite;
	wire logic hitCtrl = paddr == `REG_CTRL;
	wire logic hitStatus = paddr == `REG_STATUS;
	wire logic hitEvent = paddr == `REG_EVENT;
	wire logic hitMap = paddr == `REG_IRQMAP;
	wire logic mapped = hitCtrl | hitStatus | hitEvent | hitMap;
	wire logic [5:0] evStrobe = (wrEn & hitEvent) ? pwdata[5:0] : 6'h00;
	wire logic pollMode = ctrl_reg[`CTRL_POLL_MODE];
	wire logic initActiveLow = ctrl_reg[`CTRL_INIT_LOW];
	wire logic coprocOff = ctrl_reg[`CTRL_COPROC_OFF];

	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// Control and routing registers
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg <= `CTRL_RESET_VAL;
			irqMap_reg <= 32'h0000_0000;
		end else begin
			if (wrEn & hitCtrl) begin
				ctrl_reg <= pwdata;
			end
			if (wrEn & hitMap) begin
				irqMap_reg <= {16'h0000, pwdata[15:0]};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus ownership and master cycle
	bus_state_t state_reg, state_next;
	logic [31:0] adOut_next;
	logic [3:0] cbe_next;
	logic parDrive_reg;
	logic isWrite_reg;
	logic [31:0] wData_reg;
	logic [3:0] wBe_reg;
	wire logic anyMasterReq = (|dmaRequest) | isaMasterReq | ideMasterReq | usbMasterReq;

	// Even parity over AD and command/byte enables
	function automatic logic evenPar(input logic [31:0] ad, input logic [3:0] cbe);
		evenPar = ^{ad, cbe};
	endfunction

	// Ownership and cycle sequence
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			BUS_IDLE: if (anyMasterReq) state_next = BUS_REQ;
			BUS_REQ: begin
				if (!anyMasterReq) state_next = BUS_IDLE;
				else if (granted && mstStart) state_next = BUS_ADDR;
			end
			BUS_ADDR: state_next = BUS_DATA;
			BUS_DATA: state_next = BUS_PAR;
			BUS_PAR: state_next = anyMasterReq ? BUS_REQ : BUS_IDLE;
			default: state_next = BUS_IDLE;
		endcase
	end

	wire logic inAddr = state_reg == BUS_ADDR;
	wire logic inData = state_reg == BUS_DATA;
	wire logic owning = (state_reg != BUS_IDLE) & granted;
	wire logic tgtClaim = tgtPositiveHit | tgtSubtractiveHit;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= BUS_IDLE;
			isWrite_reg <= 1'b0;
			wData_reg <= 32'h0000_0000;
			wBe_reg <= 4'h0;
		end else begin
			state_reg <= state_next;
			if (state_reg == BUS_REQ && state_next == BUS_ADDR) begin
				isWrite_reg <= mstWrite;
				wData_reg <= mstData;
				wBe_reg <= mstByteEn;
			end
		end
	end

	// Drive values for AD and command/byte enables
	always_comb begin
		adOut_next = 32'h0000_0000;
		cbe_next = 4'hf;
		if (state_reg == BUS_REQ && state_next == BUS_ADDR) begin
			adOut_next = mstAddr;
			cbe_next = mstCmd;
		end else if (inAddr) begin
			adOut_next = isWrite_reg ? wData_reg : 32'h0000_0000;
			cbe_next = ~wBe_reg;
		end else if (tgtClaim && tgtReadData) begin
			adOut_next = tgtData;
			cbe_next = ~tgtByteEn;
		end
	end

	// Outputs registered, parity one clock behind its phase
	logic adOe_next;
	assign adOe_next = ~((state_reg == BUS_REQ && state_next == BUS_ADDR) | (inAddr & isWrite_reg)
		| (tgtClaim & tgtReadData));
	logic parEn_next;
	assign parEn_next = inAddr | (inData & isWrite_reg);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			adOut <= 32'h0000_0000;
			adOe_n <= 1'b1;
			cmd_byte_enable_n <= 4'hf;
			cbeOe_n <= 1'b1;
			parDrive_reg <= 1'b0;
			parOut <= 1'b0;
			parOe_n <= 1'b1;
			target_claim_n <= 1'b1;
			claimOe_n <= 1'b1;
			bus_own_request_n <= 1'b1;
			mstDone <= 1'b0;
		end else begin
			adOut <= adOut_next;
			adOe_n <= adOe_next;
			cmd_byte_enable_n <= cbe_next;
			cbeOe_n <= ~((state_reg == BUS_REQ && state_next == BUS_ADDR) | inAddr);
			// Target read data goes out at this edge, so its parity enable waits one clock
			parDrive_reg <= tgtClaim & tgtReadData;
			parOut <= evenPar(adOut, cmd_byte_enable_n);
			parOe_n <= ~(parEn_next | parDrive_reg);
			target_claim_n <= ~tgtClaim;
			claimOe_n <= ~tgtClaim;
			bus_own_request_n <= ~(state_next != BUS_IDLE);
			mstDone <= inData;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// DMA acknowledge after grant
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			dma_acknowledge_n <= 7'h7f;
		end else begin
			dma_acknowledge_n <= owning ? ~dmaRequest : 7'h7f;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// PCI interrupt inputs, direct or polled
	logic [2:0] pollSel_reg;
	logic [7:0] irqLevel_reg;
	logic [1:0] pollWait_reg;

	// Poll select walks eight slots; result sampled after settling through sync
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pollSel_reg <= 3'h0;
			pollWait_reg <= 2'h0;
			irqLevel_reg <= 8'h00;
		end else if (pollMode) begin
			pollWait_reg <= pollWait_reg + 2'h1;
			if (pollWait_reg == 2'h3) begin
				irqLevel_reg[pollSel_reg] <= ~irqPins[0];
				pollSel_reg <= pollSel_reg + 3'h1;
			end
		end else begin
			irqLevel_reg <= {4'h0, ~irqPins};
			pollWait_reg <= 2'h0;
		end
	end

	assign pciIrqLevel = irqLevel_reg;
	assign pci_irq_b_or_sel0Out = pollSel_reg[0];
	assign pci_irq_c_or_sel1Out = pollSel_reg[1];
	assign pci_irq_d_or_sel2Out = pollSel_reg[2];
	assign pci_irq_b_or_sel0Oe_n = ~pollMode;
	assign pci_irq_c_or_sel1Oe_n = ~pollMode;
	assign pci_irq_d_or_sel2Oe_n = ~pollMode;

	////////////////////////////////////////////////////////////////////////////////
	// CPU interrupts, reset and initialize
	logic nmi_reg;
	localparam int unsigned COLD_W = $clog2(COLD_RESET_CYCLES + 1);
	logic [COLD_W-1:0] coldCnt_reg;
	logic cold_reg;
	logic [7:0] initCnt_reg;
	logic [4:0] sysRstCnt_reg;
	logic pwrGoodPrev_reg;
	wire logic nmiSet = sysErrLow | chanChkLow | evStrobe[`EV_INT_ERROR];
	wire logic initTrigger = (cold_reg & pwrGood & (coldCnt_reg == '0)) | evStrobe[`EV_KBC_RESET]
		| evStrobe[`EV_PORT92_RESET] | evStrobe[`EV_SHUTDOWN];
	wire logic coldDone = pwrGood & (coldCnt_reg == COLD_RESET_CYCLES[$bits(coldCnt_reg)-1:0]);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			nmi_reg <= 1'b0;
			coldCnt_reg <= '0;
			cold_reg <= 1'b1;
			initCnt_reg <= 8'h00;
			sysRstCnt_reg <= 5'h00;
			pwrGoodPrev_reg <= 1'b0;
			cpuIntr <= 1'b0;
			irq13 <= 1'b0;
		end else begin
			// Set wins over clear
			nmi_reg <= nmiSet | (nmi_reg & ~evStrobe[`EV_NMI_CLEAR]);
			pwrGoodPrev_reg <= pwrGood;
			if (!pwrGood) begin
				cold_reg <= 1'b1;
				coldCnt_reg <= '0;
			end else if (coldDone) begin
				cold_reg <= 1'b0;
			end else if (cold_reg) begin
				coldCnt_reg <= coldCnt_reg + COLD_W'(1);
			end
			if (initTrigger) begin
				initCnt_reg <= 8'(`INIT_PULSE_CYC);
			end else if (initCnt_reg != 8'h00) begin
				initCnt_reg <= initCnt_reg - 8'h01;
			end
			if (evStrobe[`EV_SYS_RESET] | (pwrGood & ~pwrGoodPrev_reg)) begin
				sysRstCnt_reg <= 5'(`SYS_RESET_CYC);
			end else if (sysRstCnt_reg != 5'h00) begin
				sysRstCnt_reg <= sysRstCnt_reg - 5'h01;
			end
			cpuIntr <= picIntr;
			irq13 <= coprocOff ? ~fpuErrLow : fpuErrLow; // plain IRQ13 pin is active high
		end
	end

	assign cpuNmi = nmi_reg;
	assign cpu_cold_reset_out = cold_reg;
	assign cpuInit = (initCnt_reg != 8'h00) ^ initActiveLow;
	assign isa_reset_drive = cold_reg | (sysRstCnt_reg != 5'h00);
	assign pci_reset_out_n = ~isa_reset_drive;

	////////////////////////////////////////////////////////////////////////////////
	// Shared ISA interrupt pins toward an external APIC
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : gIrq
			assign isaIrqOut[gi] = routedIrq[gi];
			assign isaIrqOe_n[gi] = ~(irqMap_reg[gi] & ~irqFromIsa[gi]);
		end
	endgenerate

	// Read data mux
	wire logic [31:0] statusWord = {16'h0000, pciIrqLevel, 1'b0, cpuInit, isa_reset_drive, owning,
		pwrGood, cold_reg, nmi_reg, state_reg != BUS_IDLE};
	assign prdata = hitCtrl ? ctrl_reg : hitStatus ? statusWord : hitMap ? irqMap_reg : 32'h0000_0000;

endmodule
`default_nettype wire

// ### testbench/pci_side_chk.sv
// Port assertions for the PCI-side control block
`timescale 1ns/1ps
`default_nettype none
module pci_side_chk #(
	parameter int unsigned COLD_RESET_CYCLES = 20
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [6:0] dmaRequest,
	input wire logic isaMasterReq,
	input wire logic ideMasterReq,
	input wire logic usbMasterReq,
	input wire logic [31:0] adOut,
	input wire logic adOe_n,
	input wire logic [3:0] cmd_byte_enable_n,
	input wire logic cbeOe_n,
	input wire logic parOut,
	input wire logic parOe_n,
	input wire logic system_error_in_n,
	input wire logic bus_own_request_n,
	input wire logic bus_own_grant_n,
	input wire logic [6:0] dma_acknowledge_n,
	input wire logic cpuNmi,
	input wire logic cpu_cold_reset_out,
	input wire logic power_good_in,
	input wire logic isa_reset_drive,
	input wire logic pci_reset_out_n
);
	int pgCnt;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////////
	// Cycles with power good high, saturating past the release point
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			pgCnt <= 0;
		else if (!power_good_in)
			pgCnt <= 0;
		else if (pgCnt < COLD_RESET_CYCLES + 9)
			pgCnt <= pgCnt + 1;
	end
	////////////////////////////////////////////////////////////////
	a_pci_rst_inv: assert property (pci_reset_out_n == !isa_reset_drive)
		else $error("pci reset not inverse");
	a_cold_held: assert property (pgCnt < COLD_RESET_CYCLES |-> cpu_cold_reset_out)
		else $error("cold reset left early");
	a_cold_done: assert property (pgCnt == COLD_RESET_CYCLES + 8 |-> !cpu_cold_reset_out)
		else $error("cold reset stuck");
	a_nmi_serr: assert property (!system_error_in_n [*3] |-> ##[0:2] cpuNmi)
		else $error("no nmi on system error");
	a_req_raise: assert property ($rose(|{dmaRequest, isaMasterReq, ideMasterReq, usbMasterReq})
		|-> ##[1:4] !bus_own_request_n) else $error("no bus request");
	a_dack_grant: assert property (bus_own_grant_n [*4] |-> &dma_acknowledge_n)
		else $error("dma ack without grant");
	a_par_even: assert property (!parOe_n && !$past(cbeOe_n) && !$past(adOe_n)
		|-> parOut == ^{$past(adOut), $past(cmd_byte_enable_n)}) else $error("bad parity");
	a_par_next: assert property (!cbeOe_n && !adOe_n |=> !parOe_n)
		else $error("parity not driven");
endmodule
bind pci_side_control pci_side_chk #(.COLD_RESET_CYCLES(COLD_RESET_CYCLES)) chk (.sys_clk, .rst_b, .dmaRequest,
	.isaMasterReq, .ideMasterReq, .usbMasterReq, .adOut, .adOe_n, .cmd_byte_enable_n, .cbeOe_n, .parOut,
	.parOe_n, .system_error_in_n, .bus_own_request_n, .bus_own_grant_n, .dma_acknowledge_n, .cpuNmi,
	.cpu_cold_reset_out, .power_good_in, .isa_reset_drive, .pci_reset_out_n);
`default_nettype wire

// ### testbench/pci_far_side.sv
// Far side model: bus arbiter and interrupt poll encoder
`timescale 1ns/1ps
`default_nettype none
module pci_far_side (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [3:0] grantDelay,
	input wire logic [7:0] irqPattern,
	input wire logic bus_own_request_n,
	output logic bus_own_grant_n,
	input wire logic pci_irq_b_or_sel0Out,
	input wire logic pci_irq_b_or_sel0Oe_n,
	input wire logic pci_irq_c_or_sel1Out,
	input wire logic pci_irq_c_or_sel1Oe_n,
	input wire logic pci_irq_d_or_sel2Out,
	input wire logic pci_irq_d_or_sel2Oe_n,
	output logic pci_irq_a_or_poll_in,
	output logic pci_irq_b_or_sel0,
	output logic pci_irq_c_or_sel1,
	output logic pci_irq_d_or_sel2
);
	logic [3:0] waitCnt;
	// Grant after grantDelay cycles of request, withdrawn with it
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			waitCnt <= 4'h0;
			bus_own_grant_n <= 1'b1;
		end else if (bus_own_request_n) begin
			waitCnt <= 4'h0;
			bus_own_grant_n <= 1'b1;
		end else if (waitCnt == grantDelay)
			bus_own_grant_n <= 1'b0;
		else
			waitCnt <= waitCnt + 4'h1;
	end
	// Pin levels: the design's drive when enabled, else the interrupt line
	assign pci_irq_b_or_sel0 = pci_irq_b_or_sel0Oe_n ? ~irqPattern[1] : pci_irq_b_or_sel0Out;
	assign pci_irq_c_or_sel1 = pci_irq_c_or_sel1Oe_n ? ~irqPattern[2] : pci_irq_c_or_sel1Out;
	assign pci_irq_d_or_sel2 = pci_irq_d_or_sel2Oe_n ? ~irqPattern[3] : pci_irq_d_or_sel2Out;
	// Encoder returns the selected interrupt on A, active low
	assign pci_irq_a_or_poll_in = pci_irq_b_or_sel0Oe_n ? ~irqPattern[0]
		: ~irqPattern[{pci_irq_d_or_sel2, pci_irq_c_or_sel1, pci_irq_b_or_sel0}];
endmodule
`default_nettype wire

// ### testbench/pci_side_control_tb.sv
// Self-checking bench for the PCI-side control block
`timescale 1ns/1ps
`default_nettype none
`include "pci_side_defs.svh"
module pci_side_control_tb;
	localparam int unsigned COLD = 20;
	typedef struct {logic [31:0] ctrl; logic [7:0] pat; logic [7:0] lvl;} row_t;
	row_t rows[4] = '{'{32'h0, 8'ha5, 8'h05}, '{32'h2, 8'h0a, 8'h0a}, '{32'h1, 8'h5a, 8'h5a}, '{32'h43, 8'h81, 8'h81}};
	logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, isaMasterReq, ideMasterReq, usbMasterReq;
	logic mstStart, mstWrite, mstDone, tgtPositiveHit, tgtSubtractiveHit, tgtReadData, adOe_n, cbeOe_n;
	logic parOut, parOe_n, target_claim_n, claimOe_n, system_error_in_n, bus_own_request_n, bus_own_grant_n;
	logic pci_irq_a_or_poll_in, pci_irq_b_or_sel0, pci_irq_c_or_sel1, pci_irq_d_or_sel2, err;
	logic pci_irq_b_or_sel0Out, pci_irq_b_or_sel0Oe_n, pci_irq_c_or_sel1Out, pci_irq_c_or_sel1Oe_n;
	logic pci_irq_d_or_sel2Out, pci_irq_d_or_sel2Oe_n, picIntr, cpuIntr, cpuNmi, cpuInit, cpu_cold_reset_out;
	logic power_good_in, isa_channel_check_n, fpu_error_in_n, irq13, isa_reset_drive, pci_reset_out_n;
	logic [3:0] mstCmd, mstByteEn, tgtByteEn, cmd_byte_enable_n, grantDelay;
	logic [6:0] dmaRequest, dma_acknowledge_n;
	logic [7:0] pciIrqLevel, irqPattern;
	logic [11:0] paddr;
	logic [15:0] routedIrq, irqFromIsa, isaIrqOut, isaIrqOe_n;
	logic [31:0] pwdata, prdata, mstAddr, mstData, tgtData, adIn, adOut, rd;
	int n_mismatch = 0;
	int n_compared = 0;
	int cyc = 0;
	pci_side_control #(.COLD_RESET_CYCLES(COLD)) uut (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .dmaRequest, .isaMasterReq, .ideMasterReq, .usbMasterReq, .mstStart,
		.mstWrite, .mstAddr, .mstCmd, .mstData, .mstByteEn, .mstDone, .tgtPositiveHit, .tgtSubtractiveHit,
		.tgtReadData, .tgtData, .tgtByteEn, .adIn, .adOut, .adOe_n, .cmd_byte_enable_n, .cbeOe_n, .parOut,
		.parOe_n, .target_claim_n, .claimOe_n, .system_error_in_n, .bus_own_request_n, .bus_own_grant_n,
		.pci_irq_a_or_poll_in, .pci_irq_b_or_sel0, .pci_irq_b_or_sel0Out, .pci_irq_b_or_sel0Oe_n,
		.pci_irq_c_or_sel1, .pci_irq_c_or_sel1Out, .pci_irq_c_or_sel1Oe_n, .pci_irq_d_or_sel2,
		.pci_irq_d_or_sel2Out, .pci_irq_d_or_sel2Oe_n, .pciIrqLevel, .dma_acknowledge_n, .picIntr, .cpuIntr,
		.cpuNmi, .cpuInit, .cpu_cold_reset_out, .power_good_in, .isa_channel_check_n, .fpu_error_in_n, .irq13,
		.isa_reset_drive, .pci_reset_out_n, .routedIrq, .irqFromIsa, .isaIrqOut, .isaIrqOe_n);
	pci_far_side far (.sys_clk, .rst_b, .grantDelay, .irqPattern, .bus_own_request_n, .bus_own_grant_n,
		.pci_irq_b_or_sel0Out, .pci_irq_b_or_sel0Oe_n, .pci_irq_c_or_sel1Out, .pci_irq_c_or_sel1Oe_n,
		.pci_irq_d_or_sel2Out, .pci_irq_d_or_sel2Oe_n, .pci_irq_a_or_poll_in, .pci_irq_b_or_sel0,
		.pci_irq_c_or_sel1, .pci_irq_d_or_sel2);
	always #2 sys_clk = ~sys_clk;
	// Hang guard
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			close_out();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// One APB transfer; data and error taken at the completing edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do
			@(posedge sys_clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		{sys_clk, rst_b, psel, penable, pwrite, isaMasterReq, ideMasterReq, usbMasterReq, mstStart} = '0;
		{tgtPositiveHit, tgtSubtractiveHit, tgtReadData, picIntr, power_good_in} = '0;
		{paddr, pwdata, dmaRequest, mstAddr, mstData, tgtData, tgtByteEn, adIn, routedIrq, irqFromIsa} = '0;
		{irqPattern, grantDelay} = '0;
		{mstWrite, mstCmd, mstByteEn} = 9'h175;
		{system_error_in_n, isa_channel_check_n, fpu_error_in_n} = 3'b111;
		tick(20);
		chk("released", 5'h1f, {adOe_n, cbeOe_n, parOe_n, claimOe_n, bus_own_request_n});
		chk("pci reset", 0, pci_reset_out_n);
		rst_b <= 1'b1;
		power_good_in <= 1'b1;
		tick(COLD + 10);
		apb(0, `REG_CTRL, 0);
		chk("ctrl reset", `CTRL_RESET_VAL, rd);
		apb(0, `REG_STATUS, 0);
		chk("status", 32'h0000_0008, rd);
		apb(1, 12'h010, '1);
		chk("unmapped", 1, err);
		foreach (rows[i]) begin
			apb(1, `REG_CTRL, rows[i].ctrl);
			irqPattern <= rows[i].pat;
			tick(100);
			chk("irq levels", rows[i].lvl, pciIrqLevel);
			chk("sel drive", {3{~rows[i].ctrl[0]}}, {pci_irq_b_or_sel0Oe_n, pci_irq_c_or_sel1Oe_n, pci_irq_d_or_sel2Oe_n});
			chk("init idle", rows[i].ctrl[1], cpuInit);
			chk("irq13 plain", rows[i].ctrl[6], irq13);
		end
		apb(1, `REG_CTRL, 0);
		fpu_error_in_n <= 1'b0;
		picIntr <= 1'b1;
		tick(6);
		chk("irq13", 1, irq13);
		chk("intr", 1, cpuIntr);
		fpu_error_in_n <= 1'b1;
		picIntr <= 1'b0;
		for (int k = 0; k < 3; k++) begin
			if (k == 2)
				apb(1, `REG_EVENT, 32'h1 << `EV_INT_ERROR);
			{system_error_in_n, isa_channel_check_n} <= k == 0 ? 2'b01 : k == 1 ? 2'b10 : 2'b11;
			tick(3);
			{system_error_in_n, isa_channel_check_n} <= 2'b11;
			tick(5);
			chk("nmi", 1, cpuNmi);
			apb(1, `REG_EVENT, 32'h1 << `EV_NMI_CLEAR);
			tick(2);
			chk("nmi clear", 0, cpuNmi);
		end
		for (int b = 0; b < 3; b++) begin
			apb(1, `REG_EVENT, 32'h1 << b);
			tick(4);
			chk("init pulse", 1, cpuInit);
			tick(20);
			chk("init end", 0, cpuInit);
		end
		tgtData <= 32'h0000_0001;
		tgtByteEn <= 4'hf;
		for (int k = 0; k < 2; k++) begin
			{tgtPositiveHit, tgtSubtractiveHit} <= k ? 2'b01 : 2'b10;
			tgtReadData <= (k == 1);
			tick(3);
			chk("claim", 0, {claimOe_n, target_claim_n});
			if (k == 1)
				chk("target read par", 3'b001, {adOe_n, parOe_n, parOut});
			{tgtPositiveHit, tgtSubtractiveHit} <= 2'b00;
			tgtReadData <= 1'b0;
			tick(3);
		end
		routedIrq <= 16'h1234;
		apb(1, `REG_IRQMAP, 32'h00f0);
		tick(1);
		chk("apic oe", 16'hff0f, isaIrqOe_n);
		chk("apic out", 16'h0030, isaIrqOut & 16'h00f0);
		mstAddr <= 32'h8000_1000;
		mstData <= 32'hdead_beef;
		for (int k = 0; k < 4; k++) begin
			grantDelay <= 4'(k * 3);
			{dmaRequest[2], isaMasterReq, ideMasterReq, usbMasterReq} <= 4'b1000 >> k;
			while (bus_own_grant_n) @(posedge sys_clk);
			if (k == 0) begin
				while (dma_acknowledge_n === 7'h7f) @(posedge sys_clk);
				chk("dack", 7'h7b, dma_acknowledge_n);
			end
			mstStart <= 1'b1;
			while (cbeOe_n !== 1'b0) @(posedge sys_clk);
			chk("address", 32'h8000_1000, adOut);
			chk("command", 4'h7, cmd_byte_enable_n);
			tick(1);
			chk("data", 32'hdead_beef, adOut);
			chk("byte en", 4'ha, cmd_byte_enable_n);
			while (mstDone !== 1'b1) @(posedge sys_clk);
			mstStart <= 1'b0;
			{dmaRequest[2], isaMasterReq, ideMasterReq, usbMasterReq} <= 4'h0;
			tick(8);
			chk("req drop", 1, bus_own_request_n);
		end
		apb(1, `REG_EVENT, 32'h1 << `EV_SYS_RESET);
		tick(3);
		chk("isa reset", 1, isa_reset_drive);
		tick(20);
		chk("isa reset end", 0, isa_reset_drive);
		close_out();
	end
endmodule
`default_nettype wire
